/* brs_reset_ctrl.v */
// Purpose: reset and suspend gating for a bus-attached controller core
// Assumes: clk is the bus clock; reset pins are active low, asynchronous
// Notes:   core registers live here; core writes them via wr_en/wr_data
`timescale 1ns/1ps
`default_nettype none
`include "brs_defines.vh"
module brs_reset_ctrl
#(
    parameter REG_W = `BRS_REG_W
)
(
    // clock and reset
    input  wire             clk,
    input  wire             resetn,
    // reset and suspend pins, active low reset, active high suspend
    input  wire             global_reset_in_n,
    input  wire             bus_reset_in_n,
    input  wire             suspend_in,
    // core register write port
    input  wire             wr_en,
    input  wire [REG_W-1:0] wr_data,
    // core facing results
    output reg  [REG_W-1:0] reg_q,
    output reg              core_run,
    output reg              out_enable,
    output reg              regs_preserved
);
    localparam ST_RESET = `BRS_ST_RESET;
    localparam ST_HOLD  = `BRS_ST_HOLD;
    localparam ST_RUN   = `BRS_ST_RUN;

    wire glob_n_s;
    wire busr_n_s;
    wire susp_s;
    reg  [2:0]       state_r;
    reg  [2:0]       state_nxt;
    reg  [REG_W-1:0] reg_nxt;

    // pins sampled on rising bus clock
    brs_pin_sync #(.RST_VAL(1'b0)) u_glob
    (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (global_reset_in_n),
        .level_out (glob_n_s)
    );
    brs_pin_sync #(.RST_VAL(1'b0)) u_busr
    (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (bus_reset_in_n),
        .level_out (busr_n_s)
    );
    brs_pin_sync #(.RST_VAL(1'b0)) u_susp
    (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (suspend_in),
        .level_out (susp_s)
    );

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET:
            begin
                if (glob_n_s && busr_n_s)
                    state_nxt = ST_RUN;
                else if (glob_n_s && susp_s)
                    state_nxt = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (!glob_n_s)
                    state_nxt = ST_RESET;
                else if (busr_n_s)
                    state_nxt = ST_RUN;
                else if (!susp_s)
                    state_nxt = ST_RESET;
            end
            ST_RUN:
            begin
                if (!glob_n_s)
                    state_nxt = ST_RESET;
                else if (!busr_n_s)
                    state_nxt = susp_s ? ST_HOLD : ST_RESET;
            end
            default:
                state_nxt = ST_RESET;
        endcase
    end

    always @*
    begin
        reg_nxt = reg_q;
        if (!glob_n_s)
            reg_nxt = `BRS_REG_RST;
        else if (!busr_n_s && !susp_s)
            reg_nxt = `BRS_REG_RST;
        else if (!busr_n_s)
            reg_nxt = reg_q;
        else if (wr_en && state_r == ST_RUN)
            reg_nxt = wr_data;
    end

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            state_r        <= ST_RESET;
            reg_q          <= `BRS_REG_RST;
            core_run       <= 1'b0;
            out_enable     <= 1'b0;
            regs_preserved <= 1'b0;
        end
        else
        begin
            state_r        <= state_nxt;
            reg_q          <= reg_nxt;
            core_run       <= (state_nxt == ST_RUN);
            out_enable     <= (state_nxt == ST_RUN);
            regs_preserved <= (state_nxt == ST_HOLD);
        end
    end
endmodule // brs_reset_ctrl
`default_nettype wire

/* brs_defines.vh */
// Purpose: constants for the bus reset and suspend control block
// Assumes: one clock (bus clock), synchronous active-low resetn
// Notes:   reset levels are those of the register bank
`ifndef BRS_DEFINES_VH
`define BRS_DEFINES_VH
`define BRS_REG_W        8
`define BRS_REG_RST      8'h00
`define BRS_SYNC_STAGES  3
`define BRS_ST_RESET     3'h1
`define BRS_ST_HOLD      3'h2
`define BRS_ST_RUN       3'h4
`endif

/* brs_pin_sync.v */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input arrives asynchronously to clk
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
`default_nettype none
`include "brs_defines.vh"
module brs_pin_sync
#(
    parameter RST_VAL = 1'b0
)
(
    // clock and reset
    input  wire clk,
    input  wire resetn,
    // pin and filtered level
    input  wire pin_in,
    output reg  level_out
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            s1_r      <= RST_VAL;
            s2_r      <= RST_VAL;
            s3_r      <= RST_VAL;
            level_out <= RST_VAL;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // change counts only once two late stages agree
            if (s2_r == s3_r)
                level_out <= s3_r;
        end
    end
endmodule // brs_pin_sync
`default_nettype wire

/* brs_asserts.sv */
// Purpose: checks on reset and suspend gating
// Assumes: pin to output takes 5 edges
// Notes:   sees top ports only
`timescale 1ns/1ps
`default_nettype none
module brs_asserts (
    input wire logic       clk, resetn, wr_en, suspend_in,
    input wire logic       global_reset_in_n, bus_reset_in_n,
    input wire logic [7:0] wr_data, reg_q,
    input wire logic       core_run, out_enable, regs_preserved
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire g = global_reset_in_n;
    wire b = bus_reset_in_n;
    chk_glob_clear: assert property (!g [*6] |-> !out_enable && reg_q == 8'h00)
        else $error("global reset left state");
    chk_glob_susp: assert property ((!g && suspend_in) [*6] |-> !regs_preserved)
        else $error("suspend shielded global reset");
    chk_bus_clear: assert property ((g && !b && !suspend_in) [*6] |->
        !core_run && !out_enable && reg_q == 8'h00)
        else $error("bus reset left state");
    chk_susp_keep: assert property ((g && !b && suspend_in) [*6] |->
        regs_preserved && !out_enable && $stable(reg_q))
        else $error("suspend lost contents");
    chk_run_resume: assert property ($rose(core_run) |-> out_enable && $past(b, 4))
        else $error("run started early");
    chk_write_take: assert property ((g && b) [*6] ##0 (core_run && wr_en) |=>
        reg_q == $past(wr_data))
        else $error("write not taken");
    cover property (regs_preserved);
    cover property ($rose(core_run));
    cover property (core_run && wr_en);
endmodule // brs_asserts
`default_nettype wire

/* brs_host_model.sv */
// Purpose: host side reset and suspend sources
// Assumes: mode is {suspend, bus reset, global reset}, active high
// Notes:   pins only move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module brs_host_model (
    input wire logic       clk,
    input wire logic [2:0] mode,
    output var logic       global_reset_in_n,
    output var logic       bus_reset_in_n,
    output var logic       suspend_in
);
    initial {suspend_in, bus_reset_in_n, global_reset_in_n} = 3'h0;
    always @(negedge clk)
        {suspend_in, bus_reset_in_n, global_reset_in_n} <= mode ^ 3'h3;
endmodule // brs_host_model
`default_nettype wire

/* brs_reset_ctrl_test.sv */
// Purpose: self-checking bench for reset and suspend gating
// Assumes: outputs settle within 7 cycles of a pin change
// Notes:   each row writes once, refused writes must not land
`timescale 1ns/1ps
`default_nettype none
module brs_reset_ctrl_test;
    logic clk = 0, resetn = 0, wr_en = 0;
    logic [2:0] mode = 3'h0;
    logic [7:0] wr_data = 8'h00, reg_q;
    logic core_run, out_enable, regs_preserved;
    logic global_reset_in_n, bus_reset_in_n, suspend_in;
    int err_total = 0, n_compared = 0;
    // mode, write data, {enable, run, kept, bank}
    logic [21:0] rows [6] = '{{3'h0, 8'ha5, 11'h6a5}, {3'h6, 8'h3c, 11'h1a5},
        {3'h0, 8'h3c, 11'h63c}, {3'h2, 8'h5a, 11'h000},
        {3'h0, 8'h5a, 11'h65a}, {3'h5, 8'hc3, 11'h000}};
    brs_reset_ctrl i_dut (.*);
    brs_host_model i_host (.*);
    always #20 clk = ~clk;
    task check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("errors %0d of %0d compares", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        resetn = 1;
        foreach (rows[i])
        begin
            {mode, wr_data} = rows[i][21:11];
            repeat (7) @(negedge clk);
            wr_en = 1;
            @(negedge clk);
            wr_en = 0;
            @(negedge clk);
            check({out_enable, core_run, regs_preserved, reg_q}, rows[i][10:0]);
        end
        // mid-run local reset then clean restart
        mode = 3'h0;
        repeat (7) @(negedge clk);
        resetn = 0;
        repeat (5) @(negedge clk);
        resetn = 1;
        repeat (7) @(negedge clk);
        check({out_enable, core_run, regs_preserved, reg_q}, 11'h600);
        test_done;
    end
endmodule // brs_reset_ctrl_test
bind brs_reset_ctrl brs_asserts i_chk (.*);
`default_nettype wire
